//--- verilog/dpo_out.sv
// Purpose: Parallel pixel, sync and audio output stage of a link deserializer
// Assumes: Receiver data and pixel clock are asynchronous pins; config is on clk_sys
// Notes:   Outputs are re-timed to a regenerated pixel clock
`default_nettype none

module dpo_out #(
  parameter int PERIOD_WIDTH = dpo_pkg::MCLK_PERIOD_WIDTH
) (
  input wire logic clk_sys, // System clock, 25 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic rx_pclk, // Recovered pixel clock
  input wire logic [dpo_pkg::PIXEL_WIDTH-1:0] rx_pixel, // Recovered pixel word
  input wire logic rx_line_sync, // Recovered line sync
  input wire logic rx_frame_sync, // Recovered frame sync
  input wire logic rx_valid, // Recovered data enable
  input wire logic rx_audio_clk, // Recovered audio bit clock
  input wire logic rx_audio_ws, // Recovered audio word select
  input wire logic rx_audio_da, // Recovered audio data A
  input wire logic rx_audio_db, // Recovered audio data B
  input wire logic rx_lock, // Clock recovery locked
  input wire logic power_down_input, // Low powers the stage down
  input wire logic output_enable_input, // Output state while unlocked
  input wire logic mode_sel_18bit, // 18-bit colour from the select pin
  input wire logic cfg_18bit, // 18-bit colour from configuration
  input wire logic cfg_audio_b_en, // Second audio channel enable
  input wire logic filter_en, // Control signal filter on
  input wire logic strobe_edge_select, // 1 rising strobe, 0 falling
  input wire logic [1:0] mclk_ratio, // 0 x1, 1 x2, 2 x4
  input wire logic [dpo_pkg::GPIO_COUNT-1:0] gpio_dir, // 1 drives the GPIO line
  input wire logic [dpo_pkg::GPIO_COUNT-1:0] gpio_wr, // GPIO output level
  output logic [dpo_pkg::GPIO_COUNT-1:0] gpio_rd, // GPIO pin level
  input wire logic [dpo_pkg::REG_OUT_COUNT-1:0] reg_out_sel, // Take over pin as register output
  input wire logic [dpo_pkg::REG_OUT_COUNT-1:0] reg_out_val, // Register output levels
  input wire logic [dpo_pkg::GPIO_COUNT-1:0] pixel_io_in, // Pin level of bits 0,1,8,9
  output logic [dpo_pkg::PIXEL_WIDTH-1:0] pixel_out, // Pixel data pins
  output logic [dpo_pkg::PIXEL_WIDTH-1:0] pixel_oe_n, // Pixel pin enables, low drives
  output logic line_sync_out, // Line sync pin
  output logic frame_sync_out, // Frame sync pin
  output logic pixel_valid_out, // Data enable pin
  output logic pclk_out, // Pixel clock pin
  output logic audio_clk_out, // Audio bit clock pin
  output logic audio_ws_out, // Audio word select pin
  output logic audio_da_out, // Audio data A pin
  output logic mclk_out, // Audio master clock pin
  output logic ctl_oe_n, // Enable of sync, audio, clock pins
  output logic lock_out // Lock indicator
);

  localparam int SW = dpo_pkg::PIXEL_WIDTH + 15;
  localparam int DW = dpo_pkg::PIXEL_WIDTH + 1;

  // ----------------------------------------------------------------
  // Input synchronisation and pixel clock edge
  // ----------------------------------------------------------------
  logic [SW-1:0] raw_in;
  logic [SW-1:0] sync_in;
  logic pclk_s, ls_s, fs_s, valid_s, aclk_s, aws_s, ada_s, adb_s, lock_s, pwr_s, oe_s;
  logic [dpo_pkg::PIXEL_WIDTH-1:0] pix_s;
  logic [dpo_pkg::GPIO_COUNT-1:0] pio_s;
  logic pclk_q, tick, tick_d;

  assign raw_in = {rx_pclk, rx_pixel, rx_line_sync, rx_frame_sync, rx_valid, rx_audio_clk, rx_audio_ws,
                   rx_audio_da, rx_audio_db, rx_lock, power_down_input, output_enable_input, pixel_io_in};
  assign {pclk_s, pix_s, ls_s, fs_s, valid_s, aclk_s, aws_s, ada_s, adb_s, lock_s, pwr_s, oe_s, pio_s} = sync_in;

  dpo_sync #(.WIDTH(SW)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  logic active, drive, mode18, audio_b;
  assign active = pwr_s && lock_s;
  assign drive = pwr_s && (lock_s || oe_s);
  assign mode18 = mode_sel_18bit || cfg_18bit;
  assign audio_b = mode18 && cfg_audio_b_en;
  assign tick = pclk_s && !pclk_q && active;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pclk_q <= 1'b0;
      tick_d <= 1'b0;
    end else begin
      pclk_q <= pclk_s;
      tick_d <= tick;
    end
  end

  // ----------------------------------------------------------------
  // Capture and control filtering
  // ----------------------------------------------------------------
  // Two extra stages keep data aligned with the filter's added delay
  logic [DW-1:0] cap1, cap2, cap3;
  logic ls_f, valid_f;
  logic aclk_c, aws_c, ada_c, adb_c;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cap1 <= '0;
      cap2 <= '0;
      cap3 <= '0;
      {aclk_c, aws_c, ada_c, adb_c} <= 4'h0;
    end else if (tick) begin
      cap1 <= {pix_s, fs_s};
      cap2 <= cap1;
      cap3 <= cap2;
      {aclk_c, aws_c, ada_c, adb_c} <= {aclk_s, aws_s, ada_s, adb_s};
    end
  end

  dpo_ctl_filter #(.MIN_PULSE(dpo_pkg::CTL_MIN_PULSE_PCLK)) u_filt_line (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(tick),
    .enable(filter_en),
    .din(ls_s),
    .dout(ls_f)
  );

  dpo_ctl_filter #(.MIN_PULSE(dpo_pkg::CTL_MIN_PULSE_PCLK)) u_filt_valid (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(tick),
    .enable(filter_en),
    .din(valid_s),
    .dout(valid_f)
  );

  // ----------------------------------------------------------------
  // Pin function selection
  // ----------------------------------------------------------------
  logic [DW-1:0] src;
  logic [dpo_pkg::PIXEL_WIDTH-1:0] next_pixel, next_oe_n;
  logic next_aclk, next_aws, next_ada;

  assign src = filter_en ? cap3 : cap1;

  function automatic int gpio_pos(input int idx);
    case (idx)
      0: gpio_pos = dpo_pkg::GPIO0_BIT;
      1: gpio_pos = dpo_pkg::GPIO1_BIT;
      2: gpio_pos = dpo_pkg::GPIO2_BIT;
      default: gpio_pos = dpo_pkg::GPIO3_BIT;
    endcase
  endfunction

  always_comb begin
    next_pixel = src[DW-1:1];
    next_oe_n = drive ? '0 : dpo_pkg::OE_N_RESET;
    for (int i = 0; i < dpo_pkg::GPIO_COUNT; i++) begin
      if (mode18) begin
        next_pixel[gpio_pos(i)] = gpio_wr[i];
        if (!gpio_dir[i]) begin
          next_oe_n[gpio_pos(i)] = 1'b1;
        end
      end
    end
    if (reg_out_sel[dpo_pkg::REG_PIX16]) begin
      next_pixel[dpo_pkg::REG4_BIT] = reg_out_val[dpo_pkg::REG_PIX16];
    end
    if (audio_b) begin
      next_pixel[dpo_pkg::REG5_BIT] = adb_c;
    end else if (reg_out_sel[dpo_pkg::REG_PIX17]) begin
      next_pixel[dpo_pkg::REG5_BIT] = reg_out_val[dpo_pkg::REG_PIX17];
    end
    next_aclk = reg_out_sel[dpo_pkg::REG_AUDIO_CLK] ? reg_out_val[dpo_pkg::REG_AUDIO_CLK] : aclk_c;
    next_aws = reg_out_sel[dpo_pkg::REG_AUDIO_WS] ? reg_out_val[dpo_pkg::REG_AUDIO_WS] : aws_c;
    next_ada = reg_out_sel[dpo_pkg::REG_AUDIO_DA] ? reg_out_val[dpo_pkg::REG_AUDIO_DA] : ada_c;
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // 24 pixel + 3 sync + 4 audio pins make up the parallel group
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pixel_out <= dpo_pkg::PIXEL_RESET;
      {line_sync_out, frame_sync_out, pixel_valid_out} <= 3'h0;
      {audio_clk_out, audio_ws_out, audio_da_out} <= 3'h0;
    end else if (!active) begin
      pixel_out <= dpo_pkg::PIXEL_RESET;
      {line_sync_out, frame_sync_out, pixel_valid_out} <= 3'h0;
      {audio_clk_out, audio_ws_out, audio_da_out} <= 3'h0;
    end else if (tick_d) begin
      pixel_out <= next_pixel;
      line_sync_out <= ls_f;
      frame_sync_out <= src[0];
      pixel_valid_out <= valid_f;
      {audio_clk_out, audio_ws_out, audio_da_out} <= {next_aclk, next_aws, next_ada};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pixel_oe_n <= dpo_pkg::OE_N_RESET;
      ctl_oe_n <= 1'b1;
      lock_out <= 1'b0;
      gpio_rd <= '0;
    end else begin
      pixel_oe_n <= next_oe_n;
      ctl_oe_n <= !drive;
      lock_out <= active;
      gpio_rd <= pio_s;
    end
  end

  // Data changes with the internal clock rise, so inverting it puts the
  // strobe edge in mid-period
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pclk_out <= 1'b0;
    end else if (!active) begin
      pclk_out <= 1'b0;
    end else begin
      pclk_out <= strobe_edge_select ? !pclk_q : pclk_q;
    end
  end

  // ----------------------------------------------------------------
  // Audio master clock
  // ----------------------------------------------------------------
  // Period of the bit clock is measured in system cycles; x4 needs a bit
  // clock of at least eight system cycles
  logic aclk_q, aclk_rise;
  logic [PERIOD_WIDTH-1:0] per_cnt, per_last, phase, half;

  function automatic logic [PERIOD_WIDTH-1:0] half_period(input logic [PERIOD_WIDTH-1:0] per,
                                                           input logic [1:0] ratio);
    logic [PERIOD_WIDTH-1:0] h;
    h = per >> (ratio == 2'(dpo_pkg::DPO_MCLK_X1) ? 1 : (ratio == 2'(dpo_pkg::DPO_MCLK_X2) ? 2 : 3));
    half_period = (h == '0) ? PERIOD_WIDTH'(1) : h;
  endfunction

  assign aclk_rise = audio_clk_out && !aclk_q;
  assign half = half_period(per_last, mclk_ratio);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aclk_q <= 1'b0;
      per_cnt <= '0;
      per_last <= '0;
      phase <= '0;
      mclk_out <= 1'b0;
    end else if (!active) begin
      aclk_q <= 1'b0;
      per_cnt <= '0;
      phase <= '0;
      mclk_out <= 1'b0;
    end else begin
      aclk_q <= audio_clk_out;
      if (aclk_rise) begin
        per_last <= per_cnt + PERIOD_WIDTH'(1);
        per_cnt <= '0;
        phase <= '0;
        mclk_out <= 1'b1;
      end else begin
        if (per_cnt != '1) begin
          per_cnt <= per_cnt + PERIOD_WIDTH'(1);
        end
        if (phase >= half - PERIOD_WIDTH'(1)) begin
          phase <= '0;
          mclk_out <= !mclk_out;
        end else begin
          phase <= phase + PERIOD_WIDTH'(1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pixel_on_tick: assert property (@(posedge clk_sys) disable iff (!rst_n)
    active && $past(active) && $changed(pixel_out) |-> $past(tick_d))
    else $error("pixel output changed away from the pixel clock");

  a_pixel_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && !filter_en && !mode18 && reg_out_sel == '0 ##1 active && !filter_en
      |=> pixel_out[dpo_pkg::PIXEL_WIDTH-1:dpo_pkg::COLOR_WIDTH*2] == $past(pix_s[23:16], 2))
    else $error("red byte not carried to the pixel output");

  a_strobe_rising: assert property (@(posedge clk_sys) disable iff (!rst_n)
    active && $past(active) && strobe_edge_select && $past(strobe_edge_select) && $past(tick_d)
      |-> !pclk_out)
    else $error("pixel clock not low at data change for rising strobe");

  a_mclk_resync: assert property (@(posedge clk_sys) disable iff (!rst_n)
    active && aclk_rise |=> active |-> mclk_out)
    else $error("master clock not realigned to bit clock edge");

  a_gpio_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    drive && mode18 && gpio_dir[0] |=> !pixel_oe_n[dpo_pkg::GPIO0_BIT])
    else $error("general-purpose line 0 not driven");

  a_gpio_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode18 && !gpio_dir[2] |=> pixel_oe_n[dpo_pkg::GPIO2_BIT])
    else $error("general-purpose input 2 still driven");

  a_reg_out_audio: assert property (@(posedge clk_sys) disable iff (!rst_n)
    active && tick_d && reg_out_sel[dpo_pkg::REG_AUDIO_CLK] ##1 active
      |-> audio_clk_out == $past(reg_out_val[dpo_pkg::REG_AUDIO_CLK]))
    else $error("audio clock pin did not take register output 8");

  a_power_down: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !pwr_s |=> pixel_oe_n == dpo_pkg::OE_N_RESET && ctl_oe_n && !lock_out)
    else $error("outputs driven during power-down");

  a_lock_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pwr_s && !lock_s && !oe_s |=> ctl_oe_n && !lock_out)
    else $error("unlocked outputs ignore output enable");

endmodule // dpo_out

`default_nettype wire

//--- verilog/dpo_pkg.sv
// Purpose: Shared constants for the parallel video and audio output stage
// Assumes: One system clock; recovered pixel clock sampled as a plain input
// Notes:   Positions, counts and reset values are named once here
`default_nettype none

package dpo_pkg;

  // ----------------------------------------------------------------
  // Widths and layout
  // ----------------------------------------------------------------
  localparam int PIXEL_WIDTH = 24;
  localparam int COLOR_WIDTH = 8;
  localparam int GPIO_COUNT = 4;
  localparam int REG_OUT_COUNT = 9;
  localparam int PARALLEL_OUTPUTS = 31;
  localparam int SYNC_STAGES = 2;

  // Pixel bits that double as general-purpose lines 0..3
  localparam int GPIO0_BIT = 0;
  localparam int GPIO1_BIT = 1;
  localparam int GPIO2_BIT = 8;
  localparam int GPIO3_BIT = 9;
  // Pixel bits shared with register-driven outputs and second audio data
  localparam int REG4_BIT = 16;
  localparam int REG5_BIT = 17;
  // Register-driven output numbers on the audio pins and on pixel bits 16 and 17
  localparam int REG_AUDIO_DA = 6;
  localparam int REG_AUDIO_WS = 7;
  localparam int REG_AUDIO_CLK = 8;
  localparam int REG_PIX16 = 4;
  localparam int REG_PIX17 = 5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_NS = 40;
  localparam int PIXEL_PERIOD_NS = 320;
  localparam int SYS_PER_PIXEL = PIXEL_PERIOD_NS / SYS_PERIOD_NS;
  localparam int CTL_MIN_PULSE_PCLK = 3;
  localparam int CTL_WINDOW_PCLK = 130;
  localparam int LINE_MAX_TRANSITIONS = 2;
  localparam int FRAME_MAX_TRANSITIONS = 1;
  localparam int MCLK_PERIOD_WIDTH = 8;

  // ----------------------------------------------------------------
  // Reset values and modes
  // ----------------------------------------------------------------
  localparam logic [PIXEL_WIDTH-1:0] PIXEL_RESET = 24'h000000;
  localparam logic [PIXEL_WIDTH-1:0] OE_N_RESET = 24'hFFFFFF;

  typedef enum logic [1:0] {
    DPO_MCLK_X1,
    DPO_MCLK_X2,
    DPO_MCLK_X4
  } dpo_mclk_ratio_t;

endpackage

`default_nettype wire

//--- verilog/dpo_sync.sv
// Purpose: Two-flop synchroniser for a bundle of asynchronous inputs
// Assumes: Each bit is an independent level
// Notes:   Only the second stage leaves this module
`default_nettype none

module dpo_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [WIDTH-1:0] async_in, // Inputs from outside the domain
  output logic [WIDTH-1:0] sync_out // Synchronised copy
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // dpo_sync

`default_nettype wire

//--- verilog/dpo_ctl_filter.sv
// Purpose: Minimum-width filter for one video control signal
// Assumes: tick is a one-cycle pulse per pixel clock
// Notes:   Filter off gives zero added latency; on gives MIN-1 ticks more
`default_nettype none

module dpo_ctl_filter #(
  parameter int MIN_PULSE = dpo_pkg::CTL_MIN_PULSE_PCLK
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic tick, // Pixel clock enable
  input wire logic enable, // Filter on
  input wire logic din, // Raw control level
  output logic dout // Filtered control level
);

  logic [3:0] run;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run <= 4'h0;
      dout <= 1'b0;
    end else if (tick) begin
      if (!enable) begin
        dout <= din;
        run <= 4'h0;
      end else if (din == dout) begin
        run <= 4'h0;
      end else if (run == 4'(MIN_PULSE - 1)) begin
        dout <= din;
        run <= 4'h0;
      end else begin
        run <= run + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_filter_short_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    enable && tick && din != dout && run < 4'(MIN_PULSE - 1) |=> $stable(dout))
    else $error("filtered control changed before its minimum width");

  a_filter_off_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !enable && tick |=> dout == $past(din))
    else $error("unfiltered control did not pass on the pixel tick");

endmodule // dpo_ctl_filter

`default_nettype wire

//--- sim/dpo_src.sv
// Purpose: Model of the link receiver feeding the output stage
// Assumes: One call of send makes one pixel clock period of 320 ns
// Notes:   Pixel clock stands still low between sends
`default_nettype none

module dpo_src;
  timeunit 1ns;
  timeprecision 1ps;

  logic rx_pclk; // Recovered pixel clock
  logic [23:0] rx_pixel; // Recovered pixel word
  logic rx_line_sync; // Line sync
  logic rx_frame_sync; // Frame sync
  logic rx_valid; // Data enable
  logic [3:0] rx_audio; // Bit clock, select, data A, data B
  int since_fs;

  initial begin
    rx_pclk = 1'b0;
    rx_pixel = 24'h000000;
    rx_line_sync = 1'b0;
    rx_frame_sync = 1'b0;
    rx_valid = 1'b0;
    rx_audio = 4'h0;
    since_fs = dpo_pkg::CTL_WINDOW_PCLK;
  end

  // Data moves on the falling edge so it is stable around the rise
  task automatic send(input logic [23:0] p, input logic ls, input logic fs, input logic pv, input logic [3:0] au);
    rx_pixel = p;
    rx_line_sync = ls;
    rx_valid = pv;
    rx_audio = au;
    // A frame sync change too soon is held back, never sent early
    if (fs !== rx_frame_sync && since_fs >= dpo_pkg::CTL_WINDOW_PCLK) begin
      rx_frame_sync = fs;
      since_fs = 0;
    end
    if (since_fs < dpo_pkg::CTL_WINDOW_PCLK) begin
      since_fs = since_fs + 1;
    end
    #160 rx_pclk = 1'b1;
    #160 rx_pclk = 1'b0;
  endtask
endmodule // dpo_src

`default_nettype wire

//--- sim/testbench.sv
// Purpose: Self-checking bench for the parallel output stage
// Assumes: Partner model drives the recovered pins
// Notes:   Pixel clock runs only while the bench sends pixels
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys, rst_n, rx_lock, power_down_input, output_enable_input;
  logic mode_sel_18bit, cfg_18bit, cfg_audio_b_en, filter_en, strobe_edge_select, clr_seen, seen, ac_q, mc_q;
  logic [1:0] mclk_ratio;
  logic [3:0] gpio_dir, gpio_wr, pixel_io_in, gpio_rd;
  logic [8:0] reg_out_sel, reg_out_val;
  logic [23:0] pixel_out, pixel_oe_n;
  logic line_sync_out, frame_sync_out, pixel_valid_out, pclk_out, audio_clk_out, audio_ws_out, audio_da_out;
  logic mclk_out, ctl_oe_n, lock_out;
  logic [7:0] mc_n, mc_per;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;

  dpo_src src();

  dpo_out uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .rx_pclk(src.rx_pclk), .rx_pixel(src.rx_pixel),
    .rx_line_sync(src.rx_line_sync), .rx_frame_sync(src.rx_frame_sync), .rx_valid(src.rx_valid),
    .rx_audio_clk(src.rx_audio[3]), .rx_audio_ws(src.rx_audio[2]), .rx_audio_da(src.rx_audio[1]),
    .rx_audio_db(src.rx_audio[0]), .rx_lock(rx_lock), .power_down_input(power_down_input),
    .output_enable_input(output_enable_input), .mode_sel_18bit(mode_sel_18bit), .cfg_18bit(cfg_18bit),
    .cfg_audio_b_en(cfg_audio_b_en), .filter_en(filter_en), .strobe_edge_select(strobe_edge_select),
    .mclk_ratio(mclk_ratio), .gpio_dir(gpio_dir), .gpio_wr(gpio_wr), .gpio_rd(gpio_rd),
    .reg_out_sel(reg_out_sel), .reg_out_val(reg_out_val), .pixel_io_in(pixel_io_in),
    .pixel_out(pixel_out), .pixel_oe_n(pixel_oe_n), .line_sync_out(line_sync_out),
    .frame_sync_out(frame_sync_out), .pixel_valid_out(pixel_valid_out), .pclk_out(pclk_out),
    .audio_clk_out(audio_clk_out), .audio_ws_out(audio_ws_out), .audio_da_out(audio_da_out),
    .mclk_out(mclk_out), .ctl_oe_n(ctl_oe_n), .lock_out(lock_out)
  );

  always #20 clk_sys = ~clk_sys;

  // Watchers: sticky line sync, master clock rises per bit clock period, hang limit
  always @(posedge clk_sys) begin
    ac_q <= audio_clk_out;
    mc_q <= mclk_out;
    if (audio_clk_out && !ac_q) begin
      mc_per <= mc_n;
      mc_n <= {7'h00, mclk_out && !mc_q};
    end else if (mclk_out && !mc_q) begin
      mc_n <= mc_n + 8'h01;
    end
    if (clr_seen) begin
      seen <= 1'b0;
    end else if (line_sync_out) begin
      seen <= 1'b1;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      $display("[ERR] %0t timeout", $time);
      n_mismatch = n_mismatch + 1;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic idle(input int n);
    repeat (n) src.send(24'h000000, 1'b0, 1'b0, 1'b0, 4'h0);
  endtask

  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    {rx_lock, power_down_input, output_enable_input, mode_sel_18bit, cfg_18bit} = 5'h00;
    {cfg_audio_b_en, filter_en, strobe_edge_select, clr_seen} = 4'h0;
    mclk_ratio = 2'h0;
    {gpio_dir, gpio_wr, pixel_io_in} = 12'h000;
    {reg_out_sel, reg_out_val} = 18'h00000;
    w(6);
    chk(pixel_oe_n, 24'hFFFFFF, "reset pixel enables");
    chk({ctl_oe_n, lock_out}, 2'h2, "reset control enable and lock");
    @(posedge clk_sys);
    rst_n <= 1'b1;
    power_down_input <= 1'b1;
    rx_lock <= 1'b1;
    output_enable_input <= 1'b1;
    w(6);
    src.send(24'hA53CC3, 1'b1, 1'b1, 1'b1, 4'h0);
    w(6);
    chk(pixel_out, 24'hA53CC3, "pixel word");
    chk({line_sync_out, frame_sync_out, pixel_valid_out}, 3'h7, "sync levels");
    chk({pixel_oe_n[0], ctl_oe_n, lock_out}, 3'h1, "locked drives");
    $display("basic done");
    // Filter off passes one tick, on drops it, on passes three ticks
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      filter_en <= (i > 0);
      clr_seen <= 1'b1;
      idle(130);
      @(posedge clk_sys);
      clr_seen <= 1'b0;
      repeat (i == 2 ? 3 : 1) src.send(24'h000000, 1'b1, 1'b0, 1'b0, 4'h0);
      idle(6);
      chk(seen, (i != 1), "control pulse filter");
    end
    $display("filter done");
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_sys);
      strobe_edge_select <= s[0];
      idle(2);
      w(6);
      chk(pclk_out, s[0], "idle pixel clock level");
    end
    $display("strobe done");
    for (int r = 0; r < 2; r++) begin
      @(posedge clk_sys);
      reg_out_sel <= 9'h1F0;
      reg_out_val <= (r == 0) ? 9'h150 : 9'h0A0;
      idle(2);
      w(6);
      chk({pixel_out[17:16], audio_clk_out, audio_ws_out, audio_da_out}, (r == 0) ? 5'h0D : 5'h12,
          "register outputs");
    end
    @(posedge clk_sys);
    reg_out_val <= 9'h000;
    mode_sel_18bit <= 1'b1;
    cfg_audio_b_en <= 1'b1;
    gpio_dir <= 4'hF;
    gpio_wr <= 4'h9;
    src.send(24'h000000, 1'b0, 1'b0, 1'b0, 4'h1);
    w(6);
    chk(pixel_out[17], 1'b1, "second audio data");
    chk({pixel_out[9:8], pixel_out[1:0]}, 4'h9, "gpio drive");
    @(posedge clk_sys);
    gpio_dir <= 4'h0;
    pixel_io_in <= 4'h6;
    idle(2);
    w(6);
    chk({pixel_oe_n[9:8], pixel_oe_n[1:0], gpio_rd}, 8'hF6, "gpio input");
    @(posedge clk_sys);
    mode_sel_18bit <= 1'b0;
    cfg_18bit <= 1'b1;
    gpio_dir <= 4'hF;
    idle(2);
    w(6);
    chk({pixel_out[9:8], pixel_out[1:0]}, 4'h9, "gpio by config");
    @(posedge clk_sys);
    cfg_18bit <= 1'b0;
    // Filter still on: pixel data lags the link by two ticks
    repeat (3) src.send(24'hFFFFFF, 1'b0, 1'b0, 1'b0, 4'h0);
    w(6);
    chk({pixel_out[9:8], pixel_out[1:0]}, 4'hF, "gpio off in 24-bit");
    $display("pin sharing done");
    @(posedge clk_sys);
    reg_out_sel <= 9'h000;
    for (int r = 0; r < 3; r++) begin
      @(posedge clk_sys);
      mclk_ratio <= r[1:0];
      for (int i = 0; i < 24; i++) src.send(24'h000000, 1'b0, 1'b0, 1'b0, {i[1], 3'h0});
      chk(mc_per, 8'h01 << r, "master clock ratio");
    end
    $display("master clock done");
    @(posedge clk_sys);
    rx_lock <= 1'b0;
    w(6);
    chk(pixel_out, 24'h000000, "unlocked pixels low");
    chk({pixel_oe_n[0], ctl_oe_n, lock_out}, 3'h0, "unlocked driven low");
    @(posedge clk_sys);
    output_enable_input <= 1'b0;
    w(6);
    chk({pixel_oe_n[23:1], ctl_oe_n}, 24'hFFFFFF, "unlocked floating");
    @(posedge clk_sys);
    output_enable_input <= 1'b1;
    rx_lock <= 1'b1;
    power_down_input <= 1'b0;
    w(6);
    chk({pixel_oe_n[23:1], ctl_oe_n}, 24'hFFFFFF, "powered down floating");
    chk(lock_out, 1'b0, "powered down lock");
    $display("power done");
    test_done();
  end
endmodule // testbench

`default_nettype wire
